// ===== tms_amp_model.sv
// Purpose: Behavioural linear amplifier for the tune and ready handshake.
// Assumes: The coarse-tune request is a level from the sequencer.
// Notes:   Tuning starts when the request ends and takes TUNE_CYCLES.
`timescale 1ns/10ps

module tms_amp_model #(
  parameter int unsigned TUNE_CYCLES = 30
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic coarse_tune,
  output logic      amp_not_ready
);
  logic [15:0] cnt_q;

  // Not-ready stands from reset and from each request until tuning ends.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_q         <= 16'h0;
      amp_not_ready <= 1'h1;
    end
    else if (coarse_tune)
    begin
      cnt_q         <= 16'(TUNE_CYCLES);
      amp_not_ready <= 1'h1;
    end
    else if (cnt_q != 16'h0)
    begin
      cnt_q <= cnt_q - 16'h1;
      if (cnt_q == 16'h1)
        amp_not_ready <= 1'h0;
    end
  end
endmodule // tms_amp_model

// ===== tms_pkg.sv
// Purpose: Shared constants and carriers for the transmitter mute/tune sequencer.
// Assumes: 40 MHz system clock; AXI4-Lite register access with 32-bit data.
// Notes:   Every offset, the control reset value and each cycle count used by the design live here.
package tms_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned HOLD_TIME_S     = 2;
  // Longest-time style figures round down; whole seconds divide exactly here.
  localparam int unsigned HOLD_CYCLES     = HOLD_TIME_S * CLK_HZ;
  localparam int unsigned DEBOUNCE_TIME_US = 1000;
  localparam int unsigned DEBOUNCE_CYCLES = (DEBOUNCE_TIME_US * (CLK_HZ / 1_000_000));
  localparam int unsigned CNT_W           = 32;

  // ==========================================================================
  // Register map (byte addresses)
  // ==========================================================================
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_OUTS   = 4'h8;

  // Control register fields.
  localparam int unsigned CTRL_STANDBY = 0;
  localparam int unsigned CTRL_LSB     = 1;
  localparam int unsigned CTRL_MODE_LO = 2;
  localparam int unsigned CTRL_W       = 4;
  localparam logic [CTRL_W-1:0] CTRL_RESET_VAL = 4'h0;

  // Selectable transmission modes.
  localparam logic [1:0] MODE_SSB16 = 2'h0;
  localparam logic [1:0] MODE_DSB26 = 2'h1;
  localparam logic [1:0] MODE_CW    = 2'h2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic standby_n;          // Low energizes the amplifier standby relay.
    logic mute_n;             // Low mutes output stage and amplifier.
    logic stage_mute;         // Combined mute, high while any source active.
    logic reset_lamp;
    logic lock_lamp;
    logic ready_lamp;
    logic coarse_tune;
    logic tune;
    logic mode_enable;
    logic carrier_insert;
    logic atten16;
    logic atten26;
    logic ch1_atten;
    logic ch2_atten;
    logic sideband_route_relay;
    logic dual_channel_route_relay;
    logic tone_osc;
    logic ch1_agc_off;
    logic ch1_mute;
    logic full_power_atten;
    logic low_power_inhibit;
  } tms_out_t;

  typedef struct packed {
    logic [1:0] sync_a;
    logic [1:0] sync_b;
    logic       level;
    logic [CNT_W-1:0] cnt;
  } tms_deb_t;

endpackage

// ===== tms_sequencer.sv
// Purpose: Mute, tune and mode sequencer of a transmitter drive unit.
// Assumes: Single 40 MHz clock; pins are asynchronous and pass a four-flop synchroniser.
// Notes:   Registers reachable over AXI4-Lite; control and response outputs are registered, AXI ready outputs are decoded from state.
//
// Overview of operation
// - Standby command drives the standby output low.
// - Falling edge of lock signal sets the frequency-change fault latch.
// - Fault latch set: mute asserted, mute line low, reset lamp lit.
// - Lock lamp follows lock: off during loss, on again after.
// - Active-low mute line mutes output stage and goes to amplifier.
// - Not-ready asserts tune with its channel, carrier and attenuator actions.
// - Not-ready removes mode selector enable; mode changes ignored.
// - Reset press asserts coarse-tune-initiate towards the tuner.
// - Reset press starts a 2 second one-shot that clears the latch.
// - Mute released once latch clear and no other mute source.
// - Reset press turns off the reset lamp.
// - Ready deasserts tune and reverses all tune actions.
// - Ready restores the mode selector enable.
// - Ready lights ready lamp; operate on previously selected mode.
// - Minus-16 mode: carrier, -16dB stage, channel one and two attenuators.
// - Lower sideband energizes the sideband route relay.
// - Dual-sideband mode ignores sideband selector, energizes dual relay, ch1 atten.
// - Dual-sideband mode enables carrier and -26dB stage.
// - CW mode: tone on, ch1 gain amplifier off, sideband routing applied.
// - Stage mute is OR of sources including key idle.
// - Key mute stays released 2 seconds after keying stops.
`timescale 1ns/10ps

module tms_sequencer #(
  parameter int unsigned HOLD_CYCLES     = tms_pkg::HOLD_CYCLES,
  parameter int unsigned DEBOUNCE_CYCLES = tms_pkg::DEBOUNCE_CYCLES
) (
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  // Front panel and partner pins, asynchronous.
  input  wire logic                  reset_button,
  input  wire logic                  key_pressed,
  input  wire logic                  amp_not_ready,
  input  wire logic                  synth_lock,
  // AXI4-Lite slave.
  input  wire logic [3:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [3:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Control outputs.
  output tms_pkg::tms_out_t          ctl
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    tms_pkg::tms_deb_t [3:0]          deb;
    logic [3:0]                       deb_prev;
    logic                             fault;
    logic [tms_pkg::CNT_W-1:0]        shot_cnt;
    logic [tms_pkg::CNT_W-1:0]        key_cnt;
    logic [tms_pkg::CTRL_W-1:0]       ctrl;
    logic [1:0]                       mode_act;
    logic                             lsb_act;
    logic                             aw_got;
    logic                             w_got;
    logic [3:0]                       aw_addr;
    logic [31:0]                      w_data;
    logic [3:0]                       w_strb;
    logic                             bvalid;
    logic [1:0]                       bresp;
    logic                             rvalid;
    logic [31:0]                      rdata;
    logic [1:0]                       rresp;
    tms_pkg::tms_out_t                out;
  } tms_state_t;

  tms_state_t s_q;
  tms_state_t s_d;

  logic [3:0] pin_raw;
  assign pin_raw = {synth_lock, amp_not_ready, key_pressed, reset_button};

  // Debounced input indices.
  localparam int unsigned I_RST  = 0;
  localparam int unsigned I_KEY  = 1;
  localparam int unsigned I_NRDY = 2;
  localparam int unsigned I_LOCK = 3;

  // ==========================================================================
  // Input conditioning
  // ==========================================================================
  // Each pin passes four flops, then must hold a new level for the debounce
  // time before it is accepted; contact bounce would otherwise retrigger.
  tms_pkg::tms_deb_t [3:0] deb_d;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_deb
      always_comb
      begin
        deb_d[gi]        = s_q.deb[gi];
        deb_d[gi].sync_a = {s_q.deb[gi].sync_a[0], pin_raw[gi]};
        deb_d[gi].sync_b = {s_q.deb[gi].sync_b[0], s_q.deb[gi].sync_a[1]};
        if (s_q.deb[gi].sync_b[1] == s_q.deb[gi].level)
        begin
          deb_d[gi].cnt = '0;
        end
        else if (s_q.deb[gi].cnt >= DEBOUNCE_CYCLES[tms_pkg::CNT_W-1:0])
        begin
          deb_d[gi].level = s_q.deb[gi].sync_b[1];
          deb_d[gi].cnt   = '0;
        end
        else
        begin
          deb_d[gi].cnt = s_q.deb[gi].cnt + 1'b1;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  logic [3:0]  lvl;
  logic        rst_press;
  logic        lock_loss;
  logic        ready;
  logic        shot_active;
  logic        key_release;
  logic        do_write;
  logic [31:0] rd_word;
  logic [1:0]  mode_sel;

  always_comb
  begin
    s_d     = s_q;
    s_d.deb = deb_d;
    for (int i = 0; i < 4; i++)
    begin
      lvl[i] = s_q.deb[i].level;
    end
    s_d.deb_prev = lvl;
    rst_press    = lvl[I_RST] & ~s_q.deb_prev[I_RST];
    lock_loss    = ~lvl[I_LOCK] & s_q.deb_prev[I_LOCK];
    ready        = ~lvl[I_NRDY];
    shot_active  = (s_q.shot_cnt != '0);

    // The one-shot restarts on each press and holds the latch cleared while
    // it runs; a lock loss during that window is therefore not latched.
    if (rst_press)
    begin
      s_d.shot_cnt = HOLD_CYCLES[tms_pkg::CNT_W-1:0];
    end
    else if (shot_active)
    begin
      s_d.shot_cnt = s_q.shot_cnt - 1'b1;
    end

    if (rst_press || shot_active)
    begin
      s_d.fault = 1'b0;
    end
    else if (lock_loss)
    begin
      s_d.fault = 1'b1;
    end

    // Key hold: any key-down time reloads the count, release mutes after it.
    if (lvl[I_KEY])
    begin
      s_d.key_cnt = HOLD_CYCLES[tms_pkg::CNT_W-1:0];
    end
    else if (s_q.key_cnt != '0)
    begin
      s_d.key_cnt = s_q.key_cnt - 1'b1;
    end
    key_release = lvl[I_KEY] | (s_q.key_cnt != '0);

    // Mode selection only latches while the selector is enabled.
    mode_sel = s_q.ctrl[tms_pkg::CTRL_MODE_LO +: 2];
    if (ready)
    begin
      s_d.mode_act = mode_sel;
      s_d.lsb_act  = s_q.ctrl[tms_pkg::CTRL_LSB];
    end

    // Outputs.
    s_d.out.standby_n   = ~s_q.ctrl[tms_pkg::CTRL_STANDBY];
    s_d.out.stage_mute  = s_q.fault | ~key_release;
    s_d.out.mute_n      = ~s_q.fault;
    s_d.out.reset_lamp  = s_q.fault;
    s_d.out.lock_lamp   = lvl[I_LOCK];
    s_d.out.coarse_tune = lvl[I_RST];
    s_d.out.tune        = ~ready;
    s_d.out.ready_lamp  = ready;
    s_d.out.mode_enable = ready;
    s_d.out.ch1_mute          = ~ready;
    s_d.out.full_power_atten  = ~ready;
    s_d.out.low_power_inhibit = ~ready;
    s_d.out.carrier_insert = ~ready
                           | (s_q.mode_act == tms_pkg::MODE_SSB16)
                           | (s_q.mode_act == tms_pkg::MODE_DSB26);
    s_d.out.atten16   = ready & (s_q.mode_act == tms_pkg::MODE_SSB16);
    s_d.out.atten26   = ready & (s_q.mode_act == tms_pkg::MODE_DSB26);
    s_d.out.ch1_atten = (s_q.mode_act == tms_pkg::MODE_SSB16)
                      | (s_q.mode_act == tms_pkg::MODE_DSB26);
    s_d.out.ch2_atten = (s_q.mode_act == tms_pkg::MODE_SSB16);
    s_d.out.sideband_route_relay = s_q.lsb_act
                      & (s_q.mode_act != tms_pkg::MODE_DSB26);
    s_d.out.dual_channel_route_relay =
                        (s_q.mode_act == tms_pkg::MODE_DSB26);
    s_d.out.tone_osc    = (s_q.mode_act == tms_pkg::MODE_CW);
    s_d.out.ch1_agc_off = (s_q.mode_act == tms_pkg::MODE_CW);

    // AXI4-Lite write: address and data taken in either order.
    if (s_axi_awvalid && !s_q.aw_got && !s_q.bvalid)
    begin
      s_d.aw_got  = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_got && !s_q.bvalid)
    begin
      s_d.w_got  = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    do_write = s_q.aw_got && s_q.w_got && !s_q.bvalid;
    if (do_write)
    begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = tms_pkg::RESP_OKAY;
      if (s_q.aw_addr == tms_pkg::REG_CTRL)
      begin
        if (s_q.w_strb[0])
        begin
          s_d.ctrl = s_q.w_data[tms_pkg::CTRL_W-1:0];
        end
      end
      else if ((s_q.aw_addr != tms_pkg::REG_STATUS) && (s_q.aw_addr != tms_pkg::REG_OUTS))
      begin
        s_d.bresp = tms_pkg::RESP_SLVERR;
      end
    end
    else if (s_q.bvalid && s_axi_bready)
    begin
      s_d.bvalid = 1'b0;
    end

    // AXI4-Lite read: one cycle after the address is taken.
    case (s_axi_araddr)
      tms_pkg::REG_CTRL:   rd_word = {28'h0, s_q.ctrl};
      tms_pkg::REG_STATUS: rd_word = {24'h0, ready, s_q.fault, s_q.lsb_act,
                                      s_q.mode_act, lvl[I_LOCK], lvl[I_KEY], key_release};
      tms_pkg::REG_OUTS:   rd_word = {11'h0, s_q.out};
      default:             rd_word = 32'h0;
    endcase
    if (s_axi_arvalid && !s_q.rvalid)
    begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = rd_word;
      s_d.rresp  = (s_axi_araddr == tms_pkg::REG_CTRL || s_axi_araddr == tms_pkg::REG_STATUS
                    || s_axi_araddr == tms_pkg::REG_OUTS) ? tms_pkg::RESP_OKAY
                                                          : tms_pkg::RESP_SLVERR;
    end
    else if (s_q.rvalid && s_axi_rready)
    begin
      s_d.rvalid = 1'b0;
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  // Reset values put the device in standby-off, unmuted latch, tune pending.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_q                 <= '0;
      s_q.ctrl            <= tms_pkg::CTRL_RESET_VAL;
      s_q.out.standby_n   <= 1'b1;
      s_q.out.mute_n      <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Output drive
  // ==========================================================================
  // Control and response outputs are fields of the registered state; the AXI ready outputs are gated from it.
  assign ctl           = s_q.out;
  assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
  assign s_axi_wready  = !s_q.w_got && !s_q.bvalid;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;

endmodule // tms_sequencer

// ===== tms_sequencer_assertions.sv
// Purpose: Temporal checks on the sequencer control outputs.
// Assumes: DEBOUNCE_CYCLES of 3, so a pin level held for nine samples is on ctl one edge later.
// Notes:   Checks start one edge after reset, once outputs hold computed values.
`timescale 1ns/10ps

module tms_sequencer_assertions (
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic              reset_button,
  input wire logic              key_pressed,
  input wire logic              synth_lock,
  input wire tms_pkg::tms_out_t ctl
);
  logic settled_q;

  // Outputs keep reset values for one edge after release, so checks wait for it.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      settled_q <= 1'h0;
    else
      settled_q <= 1'h1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b || !settled_q);

  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_fault_mute: assert property (!ctl.mute_n |-> ctl.stage_mute && ctl.reset_lamp)
    else $error("mute line low without stage mute and lamp");
  a_tune_actions: assert property (ctl.tune |-> ctl.ch1_mute && ctl.carrier_insert
    && ctl.full_power_atten && ctl.low_power_inhibit && !ctl.ready_lamp && !ctl.mode_enable)
    else $error("tune state incomplete");
  a_ready_restore: assert property (!ctl.tune |-> ctl.mode_enable && ctl.ready_lamp
    && !ctl.ch1_mute && !ctl.full_power_atten)
    else $error("ready state incomplete");
  a_ssb_mode: assert property (ctl.atten16 |-> ctl.carrier_insert && ctl.ch1_atten
    && ctl.ch2_atten && !ctl.atten26)
    else $error("minus16 mode set incomplete");
  a_dual_route: assert property (ctl.dual_channel_route_relay |->
    !ctl.sideband_route_relay && ctl.ch1_atten)
    else $error("dual mode routing wrong");
  a_dual_carrier: assert property (ctl.atten26 |-> ctl.carrier_insert
    && ctl.dual_channel_route_relay)
    else $error("minus26 stage without dual mode");
  a_cw_tone: assert property (ctl.tone_osc |-> ctl.ch1_agc_off
    && !ctl.dual_channel_route_relay)
    else $error("tone without agc off");
  // The lamp register loads at the ninth sampled edge, so it is seen one edge later.
  a_lock_lamp: assert property (!synth_lock [*8] ##1 !synth_lock |=> !ctl.lock_lamp)
    else $error("lock lamp lit during lock loss");
  // The latch clears on the press edge and the lamp follows the latch one edge later.
  a_reset_press: assert property (reset_button [*8] ##1 reset_button |-> ##2
    ctl.coarse_tune && !ctl.reset_lamp && ctl.mute_n)
    else $error("reset press not acted on");
  a_key_unmute: assert property (key_pressed [*8] ##1 key_pressed |=>
    ctl.stage_mute == !ctl.mute_n)
    else $error("stage mute held while keyed");

  c_tune_end: cover property (ctl.tune ##1 !ctl.tune);
  c_cw_mode: cover property (ctl.tone_osc);
  c_fault: cover property ($fell(ctl.mute_n));

endmodule // tms_sequencer_assertions

bind tms_sequencer tms_sequencer_assertions chk (
  .clk(clk), .rst_b(rst_b), .reset_button(reset_button),
  .key_pressed(key_pressed), .synth_lock(synth_lock), .ctl(ctl)
);

// ===== tms_sequencer_tb.sv
// Purpose: Self-checking bench for the mute, tune and mode sequencer.
// Assumes: HOLD_CYCLES 50 and DEBOUNCE_CYCLES 3 keep the run short.
// Notes:   Registers are reached through one AXI4-Lite task.
`timescale 1ns/10ps

module tms_sequencer_tb;
  logic              clk = 1'h0, rst_b = 1'h0, reset_button = 1'h0;
  logic              key_pressed = 1'h0, synth_lock = 1'h1;
  logic [3:0]        awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
  logic [31:0]       wdata = 32'h0;
  logic              awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic              arvalid = 1'h0, rready = 1'h0;
  logic              awready, wready, bvalid, arready, rvalid, amp_not_ready;
  logic [1:0]        bresp, rresp, resp;
  logic [31:0]       rdata, rd;
  tms_pkg::tms_out_t ctl;
  int                failures = 0;
  int                tests_run = 0;

  // A 40 MHz clock.
  always #12.5 clk = ~clk;

  tms_sequencer #(.HOLD_CYCLES(50), .DEBOUNCE_CYCLES(3)) dut (
    .clk(clk), .rst_b(rst_b), .reset_button(reset_button), .key_pressed(key_pressed),
    .amp_not_ready(amp_not_ready), .synth_lock(synth_lock),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ctl(ctl));

  tms_amp_model #(.TUNE_CYCLES(30)) amp (
    .clk(clk), .rst_b(rst_b), .coarse_tune(ctl.coarse_tune), .amp_not_ready(amp_not_ready));

  // ==========================================================================
  // Tasks
  // ==========================================================================
  // Handshakes are judged at the rising edge itself, before that edge's updates
  // land, so the task sees exactly what the slave samples there.
  task automatic axi(input logic we, input logic [3:0] a, input logic [31:0] d);
    int   n;
    logic ha, hw, hd;
    n = 0;
    hd = 1'h0;
    @(posedge clk);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= we;
    wvalid <= we;
    bready <= we;
    arvalid <= !we;
    rready <= !we;
    while (!hd && n < 100)
    begin
      @(posedge clk);
      ha = (awvalid && awready) || (arvalid && arready);
      hw = wvalid && wready;
      hd = we ? bvalid : rvalid;
      resp = we ? bresp : rresp;
      rd = rdata;
      if (ha) awvalid <= 1'h0;
      if (ha) arvalid <= 1'h0;
      if (hw) wvalid <= 1'h0;
      n++;
    end
    bready <= 1'h0;
    rready <= 1'h0;
    if (!hd) failures++;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict;
    if (failures == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Route, dual, -16, -26, tone, carrier, ch1 atten, ch2 atten, agc off.
  function automatic logic [8:0] mode_bits(input logic [1:0] m, input logic lsb);
    logic s, d, c;
    s = (m == tms_pkg::MODE_SSB16);
    d = (m == tms_pkg::MODE_DSB26);
    c = (m == tms_pkg::MODE_CW);
    return {lsb && !d, d, s, d, c, !c, !c, s, c};
  endfunction

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial
  begin
    repeat (4) @(posedge clk);
    rst_b <= 1'h1;
    repeat (20) @(posedge clk);
    chk(32'({ctl.tune, ctl.mode_enable, ctl.ready_lamp, ctl.ch1_mute, ctl.carrier_insert,
      ctl.full_power_atten, ctl.low_power_inhibit, ctl.lock_lamp}), 32'h9f);
    axi(1'h1, tms_pkg::REG_CTRL, 32'h4);
    chk(32'(resp), 32'(tms_pkg::RESP_OKAY));
    axi(1'h0, tms_pkg::REG_STATUS, 32'h0);
    chk(32'(rd[4:3]), 32'(tms_pkg::MODE_SSB16));
    // A lock loss trips the fault latch.
    synth_lock <= 1'h0;
    repeat (10) @(posedge clk);
    chk(32'(ctl.lock_lamp), 32'h0);
    synth_lock <= 1'h1;
    repeat (15) @(posedge clk);
    chk(32'({ctl.mute_n, ctl.stage_mute, ctl.reset_lamp, ctl.lock_lamp}), 32'h7);
    // Operator reset, then the amplifier tunes and reports ready.
    // The lamp follows the cleared latch one edge after the debounced press.
    reset_button <= 1'h1;
    repeat (11) @(posedge clk);
    chk(32'({ctl.coarse_tune, ctl.reset_lamp, ctl.mute_n}), 32'h5);
    reset_button <= 1'h0;
    repeat (100) @(posedge clk);
    chk(32'({ctl.tune, ctl.mode_enable, ctl.ready_lamp, ctl.ch1_mute, ctl.mute_n,
      ctl.dual_channel_route_relay, ctl.atten26}), 32'h37);
    // Every mode with both sidebands.
    for (int m = 0; m < 3; m++)
      for (int l = 0; l < 2; l++)
      begin
        axi(1'h1, tms_pkg::REG_CTRL, 32'(m * 4 + l * 2));
        repeat (4) @(posedge clk);
        chk(32'({ctl.sideband_route_relay, ctl.dual_channel_route_relay, ctl.atten16,
          ctl.atten26, ctl.tone_osc, ctl.carrier_insert, ctl.ch1_atten, ctl.ch2_atten,
          ctl.ch1_agc_off}), 32'(mode_bits(2'(m), 1'(l))));
      end
    axi(1'h1, tms_pkg::REG_CTRL, 32'h9);
    repeat (4) @(posedge clk);
    chk(32'(ctl.standby_n), 32'h0);
    axi(1'h0, tms_pkg::REG_CTRL, 32'h0);
    chk(rd, 32'h9);
    chk(32'(resp), 32'(tms_pkg::RESP_OKAY));
    axi(1'h1, 4'hc, 32'h0);
    chk(32'(resp), 32'(tms_pkg::RESP_SLVERR));
    // Keying releases the stage mute; each press restarts the hold.
    key_pressed <= 1'h1;
    repeat (12) @(posedge clk);
    chk(32'(ctl.stage_mute), 32'h0);
    key_pressed <= 1'h0;
    repeat (40) @(posedge clk);
    key_pressed <= 1'h1;
    repeat (10) @(posedge clk);
    key_pressed <= 1'h0;
    repeat (40) @(posedge clk);
    chk(32'(ctl.stage_mute), 32'h0);
    repeat (30) @(posedge clk);
    chk(32'(ctl.stage_mute), 32'h1);
    give_verdict;
  end

  // The tests need under a thousand cycles; this cuts a hang short.
  initial
  begin
    repeat (5000) @(posedge clk);
    failures++;
    give_verdict;
  end
endmodule // tms_sequencer_tb
